// ==== logic/afd_decoder.sv ====
// Alpha-field record decoder: octet stream in, characters out
`timescale 1ns/1ps
`default_nettype none
module afd_decoder
   import afd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_oct_valid,
   input wire logic [7:0] i_oct_data,
   input wire logic i_oct_last,
   output var logic o_oct_ready,
   output var afd_char_t o_char,
   output var logic o_char_valid,
   output var logic o_done
);
   afd_dec_t q;
   afd_dec_t d;
   afd_char_t mapped;
   logic take;

   assign take = i_oct_valid && q.ready;

   afd_octet_map u_map (
      .i_octet(i_oct_data),
      .i_base(q.base),
      .o_char(mapped)
   );

   always_comb begin
      d = q;
      d.chr_valid = 1'b0;
      d.done = 1'b0;
      d.ready = 1'b1;
      if (take) begin
         case (q.st)
            ST_LEAD: begin
               if (i_oct_data == PFX_U16) begin
                  d.st = ST_U16_HI;
               end else if (i_oct_data == PFX_HALF) begin
                  d.scheme = SCH_HALF;
                  d.st = ST_COUNT;
               end else if (i_oct_data == PFX_FULL) begin
                  d.scheme = SCH_FULL;
                  d.st = ST_COUNT;
               end else begin
                  d.st = ST_PLAIN;
                  if (i_oct_data != OCT_PAD) begin
                     d.chr = '{is_ucs2: 1'b0, code: {9'h000, i_oct_data[6:0]}};
                     d.chr_valid = 1'b1;
                  end
               end
            end
            ST_PLAIN: begin
               if (i_oct_data != OCT_PAD) begin
                  d.chr = '{is_ucs2: 1'b0, code: {9'h000, i_oct_data[6:0]}};
                  d.chr_valid = 1'b1;
               end
            end
            ST_U16_HI: begin
               d.high_byte = i_oct_data;
               d.st = ST_U16_LO;
            end
            ST_U16_LO: begin
               // Pad pairs are skipped; odd trailing octet is never paired
               if (!(q.high_byte == OCT_PAD && i_oct_data == OCT_PAD)) begin
                  d.chr = '{is_ucs2: 1'b1, code: {q.high_byte, i_oct_data}};
                  d.chr_valid = 1'b1;
               end
               d.st = ST_U16_HI;
            end
            ST_COUNT: begin
               d.cnt = i_oct_data;
               d.st = ST_BASE_HI;
            end
            ST_BASE_HI: begin
               if (q.scheme == SCH_HALF) begin
                  d.base = {1'b0, i_oct_data, HALF_LOW_ZERO};
                  d.st = (q.cnt == CNT_ZERO) ? ST_DRAIN : ST_BODY;
               end else begin
                  d.base[15:8] = i_oct_data;
                  d.st = ST_BASE_LO;
               end
            end
            ST_BASE_LO: begin
               d.base[7:0] = i_oct_data;
               d.st = (q.cnt == CNT_ZERO) ? ST_DRAIN : ST_BODY;
            end
            ST_BODY: begin
               d.chr = mapped;
               d.chr_valid = 1'b1;
               d.cnt = q.cnt - CNT_ONE;
               if (q.cnt == CNT_ONE) begin
                  d.st = ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               d.st = ST_DRAIN;
            end
            default: begin
               d.st = ST_LEAD;
            end
         endcase
         if (i_oct_last) begin
            d.st = ST_LEAD;
            d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         q <= DEC_RST;
      end else begin
         q <= d;
      end
   end

   assign o_oct_ready = q.ready;
   assign o_char = q.chr;
   assign o_char_valid = q.chr_valid;
   assign o_done = q.done;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   sequence s_full_base;
      take && q.st == ST_BASE_HI && q.scheme == SCH_FULL && !i_oct_last
      ##1 take && q.st == ST_BASE_LO;
   endsequence

   sequence s_half_header;
      take && q.st == ST_LEAD && i_oct_data == PFX_HALF && !i_oct_last
      ##1 take && q.st == ST_COUNT && !i_oct_last;
   endsequence

   AST_U16_PAIR: assert property (
      take && q.st == ST_U16_LO && !(q.high_byte == OCT_PAD && i_oct_data == OCT_PAD)
      |=> o_char_valid && o_char.is_ucs2 && o_char.code == {$past(q.high_byte), $past(i_oct_data)})
      else $error("UCS2 pair decoded wrongly");

   AST_U16_ENTRY: assert property (
      take && q.st == ST_LEAD && i_oct_data == PFX_U16 && !i_oct_last
      |=> q.st == ST_U16_HI
          ##1 ($past(take) ? (q.st == ST_U16_LO || q.st == ST_LEAD) : q.st == ST_U16_HI))
      else $error("Prefix 80 not entered");

   AST_HALF_COUNT: assert property (
      s_half_header |=> q.cnt == $past(i_oct_data) && q.scheme == SCH_HALF)
      else $error("Half-page count not captured");

   AST_HALF_BASE: assert property (
      take && q.st == ST_BASE_HI && q.scheme == SCH_HALF
      |=> q.base == {1'b0, $past(i_oct_data), HALF_LOW_ZERO})
      else $error("Half-page base pointer wrong");

   AST_FULL_BASE: assert property (
      s_full_base |=> q.base == {$past(i_oct_data, 2), $past(i_oct_data)})
      else $error("Full base pointer wrong");

   AST_BODY_OFFSET: assert property (
      take && q.st == ST_BODY && i_oct_data[7]
      |=> o_char_valid && o_char.is_ucs2
          && o_char.code == $past(q.base) + {9'h000, $past(i_oct_data[6:0])})
      else $error("Offset character wrong");

   AST_BODY_DEFAULT: assert property (
      take && q.st == ST_BODY && !i_oct_data[7]
      |=> o_char_valid && !o_char.is_ucs2 && o_char.code == {9'h000, $past(i_oct_data[6:0])})
      else $error("Default character wrong");

   AST_FF_IN_COUNT: assert property (
      take && q.st == ST_BODY && i_oct_data == OCT_PAD
      |=> o_char_valid && o_char.code == $past(q.base) + OFFSET_MAX)
      else $error("FF inside count not decoded");

   AST_COUNT_STOP: assert property (
      take && q.st == ST_BODY && q.cnt == CNT_ONE && !i_oct_last
      |=> q.st == ST_DRAIN ##1 !o_char_valid)
      else $error("Characters past count");

   AST_DONE_AFTER_LAST: assert property (
      take && i_oct_last
      |=> o_done && q.st == ST_LEAD ##1 (!o_done || ($past(take) && $past(i_oct_last))))
      else $error("Done not pulsed after last octet");

   sequence s_u16_pad_pair;
      take && q.st == ST_U16_LO && q.high_byte == OCT_PAD && i_oct_data == OCT_PAD;
   endsequence

   AST_U16_PAD_SKIP: assert property (
      s_u16_pad_pair |=> !o_char_valid)
      else $error("Pad pair emitted a character");

   AST_PLAIN_CHAR: assert property (
      take && q.st == ST_PLAIN && i_oct_data != OCT_PAD
      |=> o_char_valid && !o_char.is_ucs2 && o_char.code == {9'h000, $past(i_oct_data[6:0])})
      else $error("Unprefixed character wrong");

   AST_PLAIN_PAD: assert property (
      take && q.st == ST_PLAIN && i_oct_data == OCT_PAD |=> !o_char_valid)
      else $error("Unprefixed pad emitted a character");

   AST_CHAR_NEEDS_TAKE: assert property (
      o_char_valid |-> $past(take))
      else $error("Character without a taken octet");

   AST_DONE_NEEDS_LAST: assert property (
      o_done |-> $past(take) && $past(i_oct_last))
      else $error("Done without a last octet");

   AST_READY_STAYS: assert property (
      o_oct_ready |=> o_oct_ready)
      else $error("Octet ready dropped");
endmodule
`default_nettype wire

// ==== logic/afd_octet_map.sv ====
// Maps one counted-scheme octet to a default or UCS2 character
`timescale 1ns/1ps
`default_nettype none
module afd_octet_map
   import afd_pkg::*;
(
   input wire logic [7:0] i_octet,
   input wire logic [15:0] i_base,
   output var afd_char_t o_char
);
   always_comb begin
      o_char.is_ucs2 = i_octet[7];
      if (i_octet[7]) begin
         o_char.code = i_base + {9'h000, i_octet[6:0]};
      end else begin
         o_char.code = {9'h000, i_octet[6:0]};
      end
   end
endmodule
`default_nettype wire

// ==== logic/afd_pkg.sv ====
// Shared types and constants for the alpha-field decoder
package afd_pkg;
   localparam logic [7:0] PFX_U16 = 8'h80;
   localparam logic [7:0] PFX_HALF = 8'h81;
   localparam logic [7:0] PFX_FULL = 8'h82;
   localparam logic [7:0] OCT_PAD = 8'hff;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [6:0] HALF_LOW_ZERO = 7'h00;
   localparam logic [15:0] OFFSET_MAX = 16'h007f;

   typedef enum logic [3:0] {
      ST_LEAD,
      ST_PLAIN,
      ST_U16_HI,
      ST_U16_LO,
      ST_COUNT,
      ST_BASE_HI,
      ST_BASE_LO,
      ST_BODY,
      ST_DRAIN
   } afd_state_e_t;

   typedef enum logic {
      SCH_HALF,
      SCH_FULL
   } afd_scheme_t;

   typedef struct packed {
      logic is_ucs2;
      logic [15:0] code;
   } afd_char_t;

   typedef struct packed {
      afd_state_e_t st;
      afd_scheme_t scheme;
      logic [7:0] cnt;
      logic [15:0] base;
      logic [7:0] high_byte;
      afd_char_t chr;
      logic chr_valid;
      logic done;
      logic ready;
   } afd_dec_t;

   localparam afd_dec_t DEC_RST = '{
      st: ST_LEAD,
      scheme: SCH_HALF,
      cnt: 8'h00,
      base: 16'h0000,
      high_byte: 8'h00,
      chr: '{is_ucs2: 1'b0, code: 16'h0000},
      chr_valid: 1'b0,
      done: 1'b0,
      ready: 1'b0
   };
endpackage

// ==== verification/afd_rec_src.sv ====
// Record source model feeding octets to the decoder
`timescale 1ns/1ps
`default_nettype none
module afd_rec_src (
   input wire logic i_clk,
   input wire logic i_ready,
   input wire logic i_start,
   input wire logic [71:0] i_rec,
   input wire logic [3:0] i_len,
   input wire logic i_slow,
   output var logic o_oct_valid,
   output var logic [7:0] o_oct_data,
   output var logic o_oct_last,
   output var logic o_busy
);
   logic took = 1'b0;
   logic go = 1'b0;
   logic gap = 1'b0;
   int idx = 0;
   initial begin
      o_oct_valid = 1'b0;
      o_oct_data = 8'h00;
      o_oct_last = 1'b0;
      o_busy = 1'b0;
   end
   always @(posedge i_clk) begin
      took <= o_oct_valid && i_ready;
      go <= i_start;
   end
   // Octet held until taken; idle data toggles
   always @(negedge i_clk) begin
      if (took) idx = idx + 1;
      if (go && !o_busy) begin
         o_busy = 1'b1;
         idx = 0;
      end
      gap = i_slow && took;
      if (o_busy && idx == int'(i_len)) o_busy = 1'b0;
      o_oct_valid = o_busy && !gap;
      o_oct_last = o_oct_valid && (idx == int'(i_len) - 1);
      // Records are whole and of one scheme; only t_u16, t_half and t_plain pad theirs with ff
      o_oct_data = o_oct_valid ? i_rec[71 - 8 * idx -: 8] : ~o_oct_data;
   end
endmodule
`default_nettype wire

// ==== verification/tb_afd_decoder.sv ====
// Testbench for the alpha-field decoder
`timescale 1ns/1ps
`default_nettype none
module tb_afd_decoder;
   import afd_pkg::*;
   logic clk, rst, start, slow, ovalid, olast, oready, cvalid, done, busy;
   logic [7:0] odata;
   logic [71:0] rec;
   logic [3:0] len;
   afd_char_t chr;
   afd_char_t got[$];
   int fail_count, compares, dones, cycles, i;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   afd_decoder i_dut(.i_clk(clk), .i_sys_rst(rst), .i_oct_valid(ovalid), .i_oct_data(odata),
      .i_oct_last(olast), .o_oct_ready(oready), .o_char(chr), .o_char_valid(cvalid),
      .o_done(done));
   afd_rec_src i_src(.i_clk(clk), .i_ready(oready), .i_start(start), .i_rec(rec),
      .i_len(len), .i_slow(slow), .o_oct_valid(ovalid), .o_oct_data(odata),
      .o_oct_last(olast), .o_busy(busy));
   always @(posedge clk) begin
      cycles++;
      if (cvalid === 1'b1) got.push_back(chr);
      if (done === 1'b1) dones++;
      if (cycles == 3000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic finish_test;
      if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check_char(afd_char_t g, afd_char_t e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic check_cnt(logic [7:0] g, logic [7:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic run_rec(logic [71:0] r, logic [3:0] n, logic s, logic [84:0] e, int ne);
      int k;
      got.delete();
      dones = 0;
      @(negedge clk);
      rec = r;
      len = n;
      slow = s;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (2) @(posedge clk);
      for (k = 0; k < 40 && busy; k++) @(posedge clk);
      repeat (3) @(posedge clk);
      check_cnt(8'(got.size()), 8'(ne));
      for (k = 0; k < ne && k < got.size(); k++) begin
         check_char(got[k], e[84 - 17 * k -: 17]);
      end
      check_cnt(8'(dones), 8'h01);
      check_cnt({7'h00, oready}, 8'h01);
   endtask
   task automatic t_u16;
      run_rec(72'h80_04_30_00_41_ff_ff_ff_00, 4'd8, 1'b0,
         {17'h10430, 17'h10041, 51'h0}, 2);
   endtask
   task automatic t_half;
      run_rec(72'h81_05_13_53_95_a6_41_ff_ff, 4'd9, 1'b1,
         {17'h00053, 17'h10995, 17'h109a6, 17'h00041, 17'h109ff}, 5);
   endtask
   task automatic t_half_top;
      run_rec(72'h81_02_ff_80_7f_00_00_00_00, 4'd5, 1'b0,
         {17'h17f80, 17'h0007f, 51'h0}, 2);
   endtask
   task automatic t_zero;
      run_rec(72'h81_00_13_53_00_00_00_00_00, 4'd4, 1'b0, 85'h0, 0);
   endtask
   task automatic t_full;
      run_rec(72'h82_05_05_30_2d_82_d3_2d_31, 4'd9, 1'b0,
         {17'h0002d, 17'h10532, 17'h10583, 17'h0002d, 17'h00031}, 5);
   endtask
   task automatic t_plain;
      run_rec(72'h41_ff_5a_00_00_00_00_00_00, 4'd3, 1'b1,
         {17'h00041, 17'h0005a, 51'h0}, 2);
   endtask
   initial begin
      rst = 1'b1;
      start = 1'b0;
      slow = 1'b0;
      rec = 72'h0;
      len = 4'h0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      for (i = 0; i < 5 && oready !== 1'b1; i++) @(posedge clk);
      t_u16();
      t_half();
      t_half_top();
      t_zero();
      t_full();
      t_plain();
      finish_test();
   end
endmodule
`default_nettype wire
